/* rtl/sud_pkg.sv */
// Purpose: Shared constants, types and enumerations for the serial controller with DMA
// Assumes: Single clock domain, all inputs synchronous to MCLK
// Notes:   Operation
package sud_pkg;

  localparam int          BIT_TICKS       = 16;
  localparam logic [3:0]  TICK_LAST       = 4'(BIT_TICKS - 1);
  localparam logic [2:0]  HALF_LAST       = 3'(BIT_TICKS / 2 - 1);
  localparam int          FIFO_DEPTH_DEF  = 64;
  localparam int          MAX_BURST_BYTES = 32;
  localparam int          HS_EXT_N        = 2;
  localparam int          REG_AW          = 12;

  localparam logic [1:0]  STOP_1          = 2'h0;
  localparam logic [1:0]  STOP_1P5        = 2'h1;
  localparam logic [1:0]  STOP_2          = 2'h2;
  localparam logic [1:0]  W_BYTE          = 2'h0;
  localparam logic [1:0]  W_HALF          = 2'h1;
  localparam logic [1:0]  W_WORD          = 2'h2;
  localparam logic [1:0]  MODE_DIRECT     = 2'h0;
  localparam logic [1:0]  MODE_LIST       = 2'h1;
  localparam logic [1:0]  MODE_SG         = 2'h2;
  localparam logic        DIR_TX          = 1'b0;
  localparam logic        DIR_RX          = 1'b1;

  // Descriptor: word 0 address, word 1 block bytes, word 2 next pointer
  localparam logic [1:0]  DESC_ADDR       = 2'h0;
  localparam logic [1:0]  DESC_SIZE       = 2'h1;
  localparam logic [1:0]  DESC_NEXT       = 2'h2;
  localparam int          DESC_SHIFT      = 2;
  localparam int          WORD_BYTES      = 4;

  localparam int          ST_N            = 6;
  localparam int          ST_RX           = 0;
  localparam int          ST_TX           = 1;
  localparam int          ST_PERR         = 2;
  localparam int          ST_FERR         = 3;
  localparam int          ST_OVR          = 4;
  localparam int          ST_DMA          = 5;

  typedef enum logic [2:0] {
    T_IDLE  = 3'b000,
    T_START = 3'b001,
    T_DATA  = 3'b010,
    T_PAR   = 3'b011,
    T_STOP  = 3'b100
  } sud_tx_e;

  typedef enum logic [2:0] {
    R_IDLE  = 3'b000,
    R_START = 3'b001,
    R_DATA  = 3'b010,
    R_PAR   = 3'b011,
    R_STOP  = 3'b100
  } sud_rx_e;

  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_DESC  = 3'b001,
    D_DWAIT = 3'b010,
    D_RUN   = 3'b011,
    D_WAIT  = 3'b100
  } sud_dma_e;

  typedef struct packed {
    logic [15:0] divisor;
    logic [1:0]  data_bits;
    logic        par_en;
    logic        par_odd;
    logic [1:0]  stop_sel;
  } sud_fmt_s;

  typedef struct packed {
    logic [1:0]  mode;
    logic        dir;
    logic [1:0]  src_w;
    logic [1:0]  dst_w;
    logic [2:0]  src_blen;
    logic [2:0]  dst_blen;
    logic        src_inc;
    logic        dst_inc;
    logic [15:0] blk;
    logic [31:0] addr;
    logic [1:0]  hs_sel;
  } sud_dma_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic        last;
  } sud_mem_s;

endpackage

/* rtl/sud_uart_dma.sv */
// Purpose: Serial character engine with a single-channel DMA and byte FIFO
// Assumes: RXD and all controls synchronous to MCLK; memory port acks each request once
// Notes:   Set the DMA parameter to zero for the instance without a DMA engine
`timescale 1ns/1ps
module sud_uart_dma #(
  parameter int HAS_DMA    = 1,
  parameter int FIFO_DEPTH = sud_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic                          MCLK,
  input  wire logic                          RST,
  input  wire logic                          CE,
  input  wire logic                          PWR_OFF,
  input  wire logic                          RST_RELEASE,
  input  wire logic                          PWR_GATE,
  input  wire sud_pkg::sud_fmt_s             FMT,
  input  wire logic                          RXD,
  output logic                               TXD,
  input  wire logic                          TX_VALID,
  input  wire logic [7:0]                    TX_DATA,
  output logic                               TX_READY,
  output logic                               RX_VALID,
  output logic [7:0]                         RX_DATA,
  input  wire logic                          LEGACY_MODE,
  input  wire logic [sud_pkg::REG_AW-1:0]    REG_ADDR,
  output logic [sud_pkg::REG_AW-1:0]         REG_WORD_ADDR,
  output logic                               REG_ADDR_ERR,
  input  wire sud_pkg::sud_dma_s             DMA_CFG,
  input  wire logic                          DMA_START,
  input  wire logic                          DMA_ABORT,
  input  wire logic [sud_pkg::HS_EXT_N-1:0]  HS_EXT_REQ,
  output logic                               DMA_BUSY,
  output sud_pkg::sud_mem_s                  MEM_OUT,
  input  wire logic                          MEM_ACK,
  input  wire logic [31:0]                   MEM_RDATA,
  input  wire logic [sud_pkg::ST_N-1:0]      STATUS_CLR,
  output logic [sud_pkg::ST_N-1:0]           STATUS,
  output logic                               IRQ
);
  import sud_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH);

  generate
    if (FIFO_DEPTH < 2 * WORD_BYTES || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || HAS_DMA > 1)
    begin : g_bad_cfg
      $error("sud_uart_dma: FIFO depth must be a power of two >= 8 and HAS_DMA 0 or 1");
    end
  endgenerate

  typedef struct packed {
    logic                         rel;
    logic [15:0]                  bdiv;
    logic                         btick;
    sud_tx_e                      tst;
    logic [3:0]                   tsub;
    logic [2:0]                   tbit;
    logic [2:0]                   thalf;
    logic [7:0]                   tsh;
    logic                         tpar;
    logic                         txd_n;
    sud_rx_e                      rst;
    logic [3:0]                   rsub;
    logic [2:0]                   rbit;
    logic [7:0]                   rsh;
    logic                         rperr;
    logic                         rx_valid;
    logic [7:0]                   rx_data;
    logic [REG_AW-1:0]            reg_waddr;
    logic                         reg_err;
    sud_dma_e                     dst;
    sud_dma_s                     dcfg;
    logic [31:0]                  maddr;
    logic [15:0]                  remn;
    logic [31:0]                  llp;
    logic [1:0]                   didx;
    logic [8:0]                   bbeat;
    logic                         abort;
    sud_mem_s                     mem;
    logic [FIFO_DEPTH-1:0][7:0]   fifo;
    logic [AW:0]                  wp;
    logic [AW:0]                  rp;
    logic [ST_N-1:0]              st;
  } sud_state_s;

  sud_state_s q;
  sud_state_s n;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [2:0] wbytes(input logic [1:0] w);
    case (w)
      W_BYTE:  wbytes = 3'h1;
      W_HALF:  wbytes = 3'h2;
      default: wbytes = 3'h4;
    endcase
  endfunction

  function automatic logic [7:0] dmask(input logic [1:0] db);
    dmask = 8'hff >> (2'h3 - db);
  endfunction

  function automatic logic [2:0] stop_halves(input logic [1:0] s);
    case (s)
      STOP_1P5: stop_halves = 3'h3;
      STOP_2:   stop_halves = 3'h4;
      default:  stop_halves = 3'h2;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic                  tx_by_dma;
  logic                  rx_by_dma;
  logic [AW:0]           cnt;
  logic [AW:0]           free;
  logic [HS_EXT_N+1:0]   hs;

  assign tx_by_dma = (q.dst != D_IDLE) && (q.dcfg.dir == DIR_TX);
  assign rx_by_dma = (q.dst != D_IDLE) && (q.dcfg.dir == DIR_RX);
  assign cnt       = q.wp - q.rp;
  assign free      = (AW + 1)'(FIFO_DEPTH) - cnt;
  // Peripheral-side requests first, then external lines; any may pace the channel
  assign hs        = {HS_EXT_REQ, (cnt != '0), (free >= (AW + 1)'(WORD_BYTES))};

  always_comb
  begin
    logic [AW:0]       wp;
    logic [AW:0]       rp;
    logic [ST_N-1:0]   st_set;
    logic [7:0]        tx_byte;
    logic [7:0]        rx_al;
    logic              r_end;
    logic              t_end;
    logic [1:0]        mw;
    logic [2:0]        wb;
    logic [2:0]        nb;
    logic [8:0]        beats;
    logic [8:0]        capb;
    logic              last;
    n       = q;
    wp      = q.wp;
    rp      = q.rp;
    st_set  = '0;
    tx_byte = '0;
    rx_al   = q.rsh >> (2'h3 - FMT.data_bits);
    r_end   = q.btick && (q.rsub == TICK_LAST);
    t_end   = q.btick && (q.tsub == TICK_LAST);
    mw      = (q.dcfg.dir == DIR_TX) ? q.dcfg.src_w : q.dcfg.dst_w;
    wb      = wbytes(mw);
    nb      = (q.remn < 16'(wb)) ? 3'h1 : wb;
    beats   = 9'h1 << ((q.dcfg.dir == DIR_TX) ? q.dcfg.src_blen : q.dcfg.dst_blen);
    capb    = 9'(MAX_BURST_BYTES) >> mw;
    last    = 1'b0;
    n.rx_valid  = 1'b0;
    n.reg_waddr = LEGACY_MODE ? {REG_ADDR[REG_AW-3:0], 2'b00} : REG_ADDR;
    n.reg_err   = !LEGACY_MODE && (REG_ADDR[1:0] != 2'b00);

    // Baud tick generator; a divisor of zero behaves as one
    if (q.bdiv + 16'h1 >= FMT.divisor)
    begin
      n.bdiv  = '0;
      n.btick = 1'b1;
    end
    else
    begin
      n.bdiv  = q.bdiv + 16'h1;
      n.btick = 1'b0;
    end

    // Transmitter: start, data and parity bits each last BIT_TICKS ticks
    if (q.tst != T_IDLE && q.btick)
      n.tsub = q.tsub + 4'h1;
    case (q.tst)
      T_IDLE:
      begin
        n.txd_n = 1'b0;
        // Loading only on a tick keeps the start bit a full period long
        if (q.btick && ((tx_by_dma && cnt != '0) || (!tx_by_dma && TX_VALID)))
        begin
          tx_byte = tx_by_dma ? q.fifo[rp[AW-1:0]] : TX_DATA;
          if (tx_by_dma)
            rp = rp + (AW + 1)'(1);
          n.tsh   = tx_byte & dmask(FMT.data_bits);
          n.tpar  = (^(tx_byte & dmask(FMT.data_bits))) ^ FMT.par_odd;
          n.tst   = T_START;
          n.txd_n = 1'b1;
          n.tsub  = '0;
          n.tbit  = '0;
        end
      end
      T_START:
        if (t_end)
        begin
          n.tst   = T_DATA;
          n.txd_n = ~q.tsh[0];
        end
      T_DATA:
        if (t_end)
        begin
          if (q.tbit == {1'b0, FMT.data_bits} + 3'h4)
          begin
            n.tst   = FMT.par_en ? T_PAR : T_STOP;
            n.txd_n = FMT.par_en ? ~q.tpar : 1'b0;
            n.thalf = '0;
          end
          else
          begin
            n.tsh   = q.tsh >> 1;
            n.tbit  = q.tbit + 3'h1;
            n.txd_n = ~q.tsh[1];
          end
        end
      T_PAR:
        if (t_end)
        begin
          n.tst   = T_STOP;
          n.txd_n = 1'b0;
          n.thalf = '0;
        end
      T_STOP:
        // Stop time counted in half periods so 1.5 needs no special path
        if (q.btick && q.tsub[2:0] == HALF_LAST)
        begin
          n.thalf = q.thalf + 3'h1;
          if (q.thalf + 3'h1 == stop_halves(FMT.stop_sel))
          begin
            n.tst     = T_IDLE;
            st_set[ST_TX] = 1'b1;
          end
        end
      default:
        n.tst = T_IDLE;
    endcase

    // Receiver: confirm start at mid-bit, then sample every full period
    if (q.rst != R_IDLE && q.btick)
      n.rsub = q.rsub + 4'h1;
    case (q.rst)
      R_IDLE:
        if (q.btick && !RXD)
        begin
          n.rst   = R_START;
          n.rsub  = '0;
          n.rperr = 1'b0;
        end
      R_START:
        if (q.btick && q.rsub[2:0] == HALF_LAST)
        begin
          n.rst  = RXD ? R_IDLE : R_DATA;
          n.rsub = '0;
          n.rbit = '0;
        end
      R_DATA:
        if (r_end)
        begin
          n.rsh  = {RXD, q.rsh[7:1]};
          n.rbit = q.rbit + 3'h1;
          if (q.rbit == {1'b0, FMT.data_bits} + 3'h4)
            n.rst = FMT.par_en ? R_PAR : R_STOP;
        end
      R_PAR:
        if (r_end)
        begin
          n.rperr = RXD != ((^rx_al) ^ FMT.par_odd);
          n.rst   = R_STOP;
        end
      R_STOP:
        if (r_end)
        begin
          n.rst          = R_IDLE;
          st_set[ST_RX]   = 1'b1;
          st_set[ST_FERR] = !RXD;
          st_set[ST_PERR] = q.rperr;
          if (rx_by_dma)
          begin
            if (free != '0)
            begin
              n.fifo[wp[AW-1:0]] = rx_al;
              wp = wp + (AW + 1)'(1);
            end
            else
              st_set[ST_OVR] = 1'b1;
          end
          else
          begin
            n.rx_data  = rx_al;
            n.rx_valid = 1'b1;
          end
        end
      default:
        n.rst = R_IDLE;
    endcase

    // DMA channel
    if (DMA_ABORT && q.dst != D_IDLE)
      n.abort = 1'b1;
    case (q.dst)
      D_IDLE:
        if (DMA_START && HAS_DMA != 0 && !LEGACY_MODE)
        begin
          n.dcfg  = DMA_CFG;
          n.abort = 1'b0;
          n.bbeat = '0;
          n.didx  = '0;
          wp      = '0;
          rp      = '0;
          if (DMA_CFG.mode == MODE_DIRECT)
          begin
            n.maddr = DMA_CFG.addr;
            n.remn  = DMA_CFG.blk;
            n.dst   = D_RUN;
          end
          else
          begin
            n.llp = DMA_CFG.addr;
            n.dst = D_DESC;
          end
        end
      D_DESC:
        if (q.abort)
        begin
          n.dst          = D_IDLE;
          st_set[ST_DMA] = 1'b1;
        end
        else
        begin
          n.mem.req  = 1'b1;
          n.mem.we   = 1'b0;
          n.mem.addr = q.llp + (32'(q.didx) << DESC_SHIFT);
          n.mem.size = W_WORD;
          n.mem.last = (q.didx == DESC_NEXT);
          n.dst      = D_DWAIT;
        end
      D_DWAIT:
        if (MEM_ACK)
        begin
          n.mem.req = 1'b0;
          case (q.didx)
            DESC_ADDR: n.maddr = MEM_RDATA;
            DESC_SIZE: n.remn  = MEM_RDATA[15:0];
            default:   n.llp   = MEM_RDATA;
          endcase
          n.didx = q.didx + 2'h1;
          n.dst  = (q.didx == DESC_NEXT) ? D_RUN : D_DESC;
        end
      D_RUN:
        if (q.abort || (q.remn == '0 && (q.dcfg.mode == MODE_DIRECT || q.llp == '0)))
        begin
          // Memory side done is not channel done: queued TX bytes would be stranded
          if (q.abort || q.dcfg.dir == DIR_RX || cnt == '0)
          begin
            n.dst          = D_IDLE;
            st_set[ST_DMA] = 1'b1;
          end
        end
        else if (q.remn == '0)
        begin
          n.didx = '0;
          n.dst  = D_DESC;
        end
        else if (hs[q.dcfg.hs_sel] && ((q.dcfg.dir == DIR_TX) ? (free >= (AW + 1)'(nb)) : (cnt >= (AW + 1)'(nb))))
        begin
          last       = (q.bbeat + 9'h1 >= ((beats < capb) ? beats : capb)) || (q.remn == 16'(nb));
          n.bbeat    = last ? 9'h0 : q.bbeat + 9'h1;
          n.mem.req  = 1'b1;
          n.mem.we   = q.dcfg.dir;
          n.mem.addr = q.maddr;
          n.mem.size = (nb == wb) ? mw : W_BYTE;
          n.mem.last = last;
          n.mem.wdata = '0;
          for (int i = 0; i < WORD_BYTES; i++)
            if (q.dcfg.dir == DIR_RX && 3'(i) < nb)
            begin
              n.mem.wdata[8*i +: 8] = q.fifo[rp[AW-1:0]];
              rp = rp + (AW + 1)'(1);
            end
          n.dst = D_WAIT;
        end
      D_WAIT:
        if (MEM_ACK)
        begin
          n.mem.req = 1'b0;
          for (int i = 0; i < WORD_BYTES; i++)
            if (q.dcfg.dir == DIR_TX && 3'(i) < nb)
            begin
              n.fifo[wp[AW-1:0]] = MEM_RDATA[8*i +: 8];
              wp = wp + (AW + 1)'(1);
            end
          if ((q.dcfg.dir == DIR_TX) ? q.dcfg.src_inc : q.dcfg.dst_inc)
            n.maddr = q.maddr + 32'(nb);
          n.remn = q.remn - 16'(nb);
          n.dst  = D_RUN;
        end
      default:
        n.dst = D_IDLE;
    endcase
    n.wp = wp;
    n.rp = rp;

    // Set wins over a clear in the same cycle
    n.st = (q.st & ~STATUS_CLR) | st_set;

    // Gating holds every flop except rx_valid, so the line keeps its current level
    if (PWR_GATE)
    begin
      n          = q;
      n.rx_valid = 1'b0;
    end
    if (!q.rel || PWR_OFF)
    begin
      n     = '0;
      n.rel = RST_RELEASE && !PWR_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register and outputs

  always_ff @(posedge MCLK)
  begin
    if (RST)
      q <= '0;
    else if (CE)
      q <= n;
  end

  assign TXD           = ~q.txd_n;
  assign TX_READY      = q.rel && CE && !PWR_OFF && !PWR_GATE && (q.tst == T_IDLE) && q.btick && !tx_by_dma;
  assign RX_VALID      = q.rx_valid;
  assign RX_DATA       = q.rx_data;
  assign REG_WORD_ADDR = q.reg_waddr;
  assign REG_ADDR_ERR  = q.reg_err;
  assign DMA_BUSY      = q.dst != D_IDLE;
  assign MEM_OUT       = q.mem;
  assign STATUS        = q.st;
  assign IRQ           = |q.st;

endmodule

/* testbench/sud_serial_peer.sv */
// Purpose: Line-side serial device that reads and sends characters
// Assumes: One bit time is 16 MCLK cycles; eight data bits
// Notes:   Ragged mode inverts the edges of each bit so only mid-bit sampling reads it right
`timescale 1ns/1ps
module sud_serial_peer (
  input  wire logic MCLK,
  input  wire logic TXD,
  output logic      RXD
);
  logic       par_on = 1'b0;
  logic [7:0] got = 8'h00;
  logic       got_par = 1'b0;
  logic       stop_ok = 1'b0;
  int         n_got = 0;

  initial RXD = 1'b1;

  ////////////////////////////////////////////////////////////
  always
  begin
    @(negedge TXD);
    repeat (8) @(posedge MCLK);
    for (int i = 0; i < 8; i++)
    begin
      repeat (16) @(posedge MCLK);
      got[i] = TXD;
    end
    if (par_on)
    begin
      repeat (16) @(posedge MCLK);
      got_par = TXD;
    end
    repeat (16) @(posedge MCLK);
    stop_ok = TXD;
    n_got++;
  end

  task automatic send(input logic [7:0] b, input logic par, input logic ragged);
    logic [9:0] f;
    int         n;
    f = {par, b, 1'b0};
    n = par_on ? 10 : 9;
    for (int i = 0; i < n; i++)
      for (int t = 0; t < 16; t++)
      begin
        @(negedge MCLK);
        RXD = (ragged && (t < 3 || t > 12)) ? ~f[i] : f[i];
      end
    @(negedge MCLK);
    RXD = 1'b1;
    repeat (24) @(negedge MCLK);
  endtask
endmodule

/* testbench/sud_uart_dma_sva.sv */
// Purpose: Port-level checks for the serial controller with DMA
// Assumes: Single clock; start-bit timing checked only with divisor 1
// Notes:   Release is tracked here because the held state has no port
`timescale 1ns/1ps
module sud_uart_dma_sva #(
  parameter int HAS_DMA = 1
) (
  input wire logic                     MCLK,
  input wire logic                     RST,
  input wire logic                     CE,
  input wire logic                     PWR_OFF,
  input wire logic                     RST_RELEASE,
  input wire logic                     PWR_GATE,
  input wire sud_pkg::sud_fmt_s        FMT,
  input wire logic                     TXD,
  input wire logic                     TX_VALID,
  input wire logic                     TX_READY,
  input wire logic                     LEGACY_MODE,
  input wire logic [sud_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [sud_pkg::REG_AW-1:0] REG_WORD_ADDR,
  input wire logic                     REG_ADDR_ERR,
  input wire logic                     DMA_BUSY,
  input wire logic [sud_pkg::ST_N-1:0] STATUS_CLR,
  input wire logic [sud_pkg::ST_N-1:0] STATUS,
  input wire logic                     IRQ
);
  import sud_pkg::*;
  logic rel_q;
  logic rel_d;
  logic live;

  always_comb rel_d = (RST || (PWR_OFF && CE)) ? 1'b0 : (rel_q || (RST_RELEASE && CE));
  always_ff @(posedge MCLK) rel_q <= rel_d;
  // Only edges that really update the core may be judged
  assign live = rel_q && CE && !PWR_GATE && !PWR_OFF;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////
  sequence s_low8;
    !TXD [*8];
  endsequence
  property p_start;
    TX_VALID && TX_READY && FMT.divisor == 16'h1 && CE && !PWR_GATE |=> s_low8 ##1 s_low8;
  endproperty
  property p_idle;
    TX_READY |-> TXD;
  endproperty
  property p_gate_txd;
    PWR_GATE |=> $stable(TXD);
  endproperty
  property p_gate_rdy;
    PWR_GATE |-> !TX_READY;
  endproperty
  property p_legacy;
    live && LEGACY_MODE |=> REG_WORD_ADDR == ($past(REG_ADDR) << 2) && !REG_ADDR_ERR;
  endproperty
  property p_native;
    live && !LEGACY_MODE |=> REG_WORD_ADDR == $past(REG_ADDR) && REG_ADDR_ERR == ($past(REG_ADDR) % 4 != 0);
  endproperty
  property p_no_dma;
    LEGACY_MODE && !DMA_BUSY |=> !DMA_BUSY;
  endproperty
  property p_third;
    HAS_DMA == 0 |-> !DMA_BUSY;
  endproperty
  property p_irq;
    live && (|STATUS) && STATUS_CLR == '0 |=> IRQ && (|STATUS);
  endproperty

  a_start    : assert property (p_start)    else $error("start bit not low for one bit time");
  a_idle     : assert property (p_idle)     else $error("line not at stop level while idle");
  a_gate_txd : assert property (p_gate_txd) else $error("line moved during power gating");
  a_gate_rdy : assert property (p_gate_rdy) else $error("byte accepted during power gating");
  a_legacy   : assert property (p_legacy)   else $error("legacy address not translated");
  a_native   : assert property (p_native)   else $error("native address handling wrong");
  a_no_dma   : assert property (p_no_dma)   else $error("channel started in legacy mode");
  a_third    : assert property (p_third)    else $error("channel busy without engine");
  a_irq      : assert property (p_irq)      else $error("interrupt dropped before clear");
endmodule

bind sud_uart_dma sud_uart_dma_sva #(.HAS_DMA(HAS_DMA)) u_sva (.*);

/* testbench/test_sud_uart_dma.sv */
// Purpose: Directed bench for the serial controller with DMA
// Assumes: Divisor 1, so one bit lasts 16 clocks
// Notes:   Memory acks each request at once; read data echoes the address byte
`timescale 1ns/1ps
module test_sud_uart_dma;
  import sud_pkg::*;
  logic              MCLK = 1'b0;
  logic              RST = 1'b1;
  logic              CE = 1'b1;
  logic              PWR_OFF = 1'b0;
  logic              RST_RELEASE = 1'b0;
  logic              PWR_GATE = 1'b0;
  sud_fmt_s          FMT = '{16'h1, 2'h3, 1'b0, 1'b1, STOP_1};
  logic              RXD;
  logic              TXD;
  logic              TX_VALID = 1'b0;
  logic [7:0]        TX_DATA = 8'h00;
  logic              TX_READY;
  logic              RX_VALID;
  logic [7:0]        RX_DATA;
  logic              LEGACY_MODE = 1'b0;
  logic [REG_AW-1:0] REG_ADDR = '0;
  logic [REG_AW-1:0] REG_WORD_ADDR;
  logic              REG_ADDR_ERR;
  sud_dma_s          DMA_CFG = '0;
  logic              DMA_START = 1'b0;
  logic              DMA_ABORT = 1'b0;
  logic [1:0]        HS_EXT_REQ = 2'h0;
  logic              DMA_BUSY;
  sud_mem_s          MEM_OUT;
  logic              MEM_ACK = 1'b0;
  logic [31:0]       MEM_RDATA = 32'h0;
  logic [ST_N-1:0]   STATUS_CLR = '0;
  logic [ST_N-1:0]   STATUS;
  logic              IRQ;
  int                n_errors = 0;
  int                comparisons = 0;
  int                cycles = 0;
  logic [7:0]        rx_last = 8'h00;
  logic [31:0]       mem_log[$];

  always #5 MCLK = ~MCLK;
  sud_uart_dma dut (.*);
  sud_serial_peer peer (.*);

  // Idle read data toggles so a stale value is never mistaken for an answer
  always @(negedge MCLK)
  begin
    if (MEM_OUT.req === 1'b1 && !MEM_ACK)
    begin
      MEM_ACK <= 1'b1;
      MEM_RDATA <= {4{MEM_OUT.addr[7:0]}};
      mem_log.push_back(MEM_OUT.addr);
    end
    else
    begin
      MEM_ACK <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
    end
  end

  always @(posedge MCLK) if (RX_VALID === 1'b1) rx_last <= RX_DATA;

  always @(posedge MCLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge MCLK);
  endtask

  task automatic tx_byte(input logic [7:0] b);
    int k;
    k = 0;
    @(negedge MCLK);
    TX_DATA = b;
    TX_VALID = 1'b1;
    @(posedge MCLK);
    while (TX_READY !== 1'b1 && k < 600)
    begin
      k++;
      @(posedge MCLK);
    end
    @(negedge MCLK);
    TX_VALID = 1'b0;
    check("tx_taken", 1, k < 600);
  endtask

  task automatic wait_peer(input int n);
    int k;
    k = 0;
    while (peer.n_got < n && k < 2000)
    begin
      k++;
      @(negedge MCLK);
    end
    check("peer_count", n, peer.n_got);
  endtask

  task automatic pulse_start();
    DMA_START = 1'b1;
    cyc(1);
    DMA_START = 1'b0;
  endtask

  task automatic clear_status();
    STATUS_CLR = '1;
    cyc(1);
    STATUS_CLR = '0;
    cyc(2);
    check("irq_clear", 0, IRQ);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    time t0;
    int  hi;
    int  base;
    repeat (6) @(negedge MCLK);
    RST = 1'b0;
    TX_VALID = 1'b1;
    cyc(4);
    check("txd_held", 1, TXD);
    check("ready_held", 0, TX_READY);
    TX_VALID = 1'b0;
    RST_RELEASE = 1'b1;
    cyc(1);
    RST_RELEASE = 1'b0;
    cyc(2);
    check("txd_idle", 1, TXD);
    $display("test release done");

    for (int p = 0; p < 2; p++)
    begin
      FMT.par_en = p[0];
      peer.par_on = p[0];
      base = peer.n_got;
      tx_byte(8'h4b);
      wait_peer(base + 1);
      check("tx_data", 8'h4b, peer.got);
      check("tx_stop", 1, peer.stop_ok);
    end
    check("tx_parity", 1, peer.got_par);
    $display("test transmit done");

    FMT.par_en = 1'b0;
    peer.par_on = 1'b0;
    for (int s = 0; s < 3; s++)
    begin
      FMT.stop_sel = 2'(s);
      base = peer.n_got;
      fork
        begin
          tx_byte(8'h00);
          tx_byte(8'h00);
        end
        begin
          @(posedge TXD);
          t0 = $time;
          @(negedge TXD);
          hi = int'(($time - t0) / 10);
        end
      join
      wait_peer(base + 2);
      check("stop_len", 1, hi >= 16 + 8 * s && hi <= 19 + 8 * s);
    end
    FMT.stop_sel = STOP_1;
    $display("test stop bits done");

    FMT.par_en = 1'b1;
    peer.par_on = 1'b1;
    clear_status();
    peer.send(8'h96, 1'b1, 1'b1);
    check("rx_data", 8'h96, rx_last);
    check("rx_perr", 0, STATUS[ST_PERR]);
    peer.send(8'h69, 1'b0, 1'b0);
    cyc(30);
    check("rx_data2", 8'h69, rx_last);
    check("perr", 1, STATUS[ST_PERR]);
    check("irq_held", 1, IRQ);
    clear_status();
    $display("test receive done");

    for (int i = 0; i < 3; i++)
    begin
      LEGACY_MODE = (i == 0);
      REG_ADDR = 12'h004 + 12'(2 * i);
      cyc(2);
      check("word_addr", LEGACY_MODE ? {REG_ADDR[9:0], 2'b00} : REG_ADDR, REG_WORD_ADDR);
      check("addr_err", !LEGACY_MODE && REG_ADDR[1:0] != 2'b00, REG_ADDR_ERR);
    end
    DMA_CFG.blk = 16'h0002;
    DMA_CFG.addr = 32'h0000_0040;
    LEGACY_MODE = 1'b1;
    pulse_start();
    cyc(4);
    check("dma_legacy", 0, DMA_BUSY);
    check("dma_legacy_mem", 0, mem_log.size());
    LEGACY_MODE = 1'b0;
    FMT.par_en = 1'b0;
    peer.par_on = 1'b0;
    $display("test addressing done");

    for (int inc = 1; inc >= 0; inc--)
    begin
      DMA_CFG.src_inc = inc[0];
      clear_status();
      base = peer.n_got;
      pulse_start();
      wait_peer(base + 1);
      check("dma_byte0", 8'h40, peer.got);
      wait_peer(base + 2);
      check("dma_byte1", inc ? 8'h41 : 8'h40, peer.got);
      check("dma_addr1", inc ? 32'h41 : 32'h40, mem_log[1]);
      check("dma_done", 1, STATUS[ST_DMA]);
      mem_log.delete();
    end
    DMA_CFG.blk = 16'h0008;
    pulse_start();
    cyc(1);
    DMA_ABORT = 1'b1;
    cyc(1);
    DMA_ABORT = 1'b0;
    cyc(4);
    check("dma_abort", 0, DMA_BUSY);
    $display("test dma done");

    base = peer.n_got;
    tx_byte(8'h0f);
    cyc(20);
    PWR_GATE = 1'b1;
    hi = int'(TXD);
    repeat (32)
    begin
      cyc(1);
      check("gate_txd", hi, TXD);
    end
    check("gate_ready", 0, TX_READY);
    PWR_GATE = 1'b0;
    wait_peer(base + 1);
    check("gate_resume", 8'h3f, peer.got);
    cyc(100);
    PWR_OFF = 1'b1;
    cyc(1);
    PWR_OFF = 1'b0;
    TX_VALID = 1'b1;
    cyc(4);
    check("off_held", 0, TX_READY);
    TX_VALID = 1'b0;
    $display("test power gate done");
    conclude();
  end
endmodule
